// >>> rtl/iqst_regs.svh
`ifndef IQST_REGS_SVH
`define IQST_REGS_SVH

`define IQST_MV_NONE     2'b00
`define IQST_MV_LATCH    2'b01
`define IQST_MV_ADV_BUS  2'b10
`define IQST_MV_ADV_LAT  2'b11

`define IQST_ST_NONE     2'b00
`define IQST_ST_ODD      2'b01
`define IQST_ST_EVEN     2'b10

`define IQST_SYS_CLK_NS  25
`define IQST_E_HALF_NS   50
`define IQST_E_HALF_CYC  ((`IQST_E_HALF_NS + `IQST_SYS_CLK_NS - 1) / `IQST_SYS_CLK_NS)
`define IQST_MIN_BYTES   3

`endif

// >>> rtl/iqst_pkg.sv
`include "iqst_regs.svh"
`default_nettype none
package iqst_pkg;
    typedef enum logic [1:0] {
        IQST_MV_NONE    = `IQST_MV_NONE,
        IQST_MV_LATCH   = `IQST_MV_LATCH,
        IQST_MV_ADV_BUS = `IQST_MV_ADV_BUS,
        IQST_MV_ADV_LAT = `IQST_MV_ADV_LAT
    } iqst_mv_t;

    typedef enum logic [1:0] {
        IQST_ST_NONE = `IQST_ST_NONE,
        IQST_ST_ODD  = `IQST_ST_ODD,
        IQST_ST_EVEN = `IQST_ST_EVEN
    } iqst_st_t;
endpackage
`default_nettype wire

// >>> rtl/iqst_tracker.sv
`include "iqst_regs.svh"
`default_nettype none
module iqst_tracker #(
    parameter int unsigned WORD_W = 16,
    parameter int unsigned E_HALF = `IQST_E_HALF_CYC
) (
    input  wire logic              sys_clk,
    input  wire logic              rst,
    input  wire logic              fetch_valid,
    input  wire logic [WORD_W-1:0] fetch_data,
    input  wire logic              adv_req,
    input  wire logic              start_req,
    input  wire logic              start_odd,
    input  wire logic              core_busy,
    output logic                   fetch_ready,
    output logic                   bus_clock_out,
    output logic                   queue_status_hi,
    output logic                   queue_status_lo,
    output logic                   exec_start,
    output logic [7:0]             exec_opcode
);
    localparam int unsigned CNT_W = (E_HALF > 1) ? $clog2(E_HALF) : 1;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(E_HALF - 1);

    logic [CNT_W-1:0]  div_cnt;
    logic              half_end;
    logic              e_rise;
    logic              e_fall;
    logic [WORD_W-1:0] stage1;
    logic [WORD_W-1:0] stage2;
    logic [WORD_W-1:0] hold;
    logic              s1_valid;
    logic              s2_valid;
    logic              hold_valid;
    logic              odd_q;
    logic              grant;
    iqst_pkg::iqst_mv_t mv_q;
    iqst_pkg::iqst_mv_t next_mv;
    iqst_pkg::iqst_st_t st_q;
    logic [2:0]        avail;

    // E clock: every rate comes from this divider, no second domain
    assign half_end = (div_cnt == CNT_LAST);
    assign e_rise   = half_end && !bus_clock_out;
    assign e_fall   = half_end && bus_clock_out;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_cnt       <= '0;
            bus_clock_out <= 1'b0;
        end else if (half_end) begin
            div_cnt       <= '0;
            bus_clock_out <= !bus_clock_out;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // bytes the core could see from the chosen start byte onward
    always_comb begin
        avail = 3'h0;
        if (s2_valid) begin
            avail = start_odd ? 3'h1 : 3'h2;
        end
        if (s1_valid) begin
            avail = avail + 3'h2;
        end
    end

    // movement chosen for data sampled at this falling edge
    always_comb begin
        next_mv = iqst_pkg::IQST_MV_NONE;
        if (adv_req || !s2_valid) begin
            if (hold_valid) begin
                next_mv = iqst_pkg::IQST_MV_ADV_LAT;
            end else if (fetch_valid && (s1_valid || !s2_valid)) begin
                next_mv = iqst_pkg::IQST_MV_ADV_BUS;
            end
        end else if (fetch_valid && !hold_valid) begin
            next_mv = iqst_pkg::IQST_MV_LATCH;
        end
    end

    // queue stages and holding latch move only at E fall
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stage1     <= '0;
            stage2     <= '0;
            hold       <= '0;
            s1_valid   <= 1'b0;
            s2_valid   <= 1'b0;
            hold_valid <= 1'b0;
            mv_q       <= iqst_pkg::IQST_MV_NONE;
        end else if (e_fall) begin
            mv_q <= next_mv;
            case (next_mv)
                iqst_pkg::IQST_MV_LATCH: begin
                    hold       <= fetch_data;
                    hold_valid <= 1'b1;
                end
                iqst_pkg::IQST_MV_ADV_BUS: begin
                    stage2   <= stage1;
                    s2_valid <= s1_valid;
                    stage1   <= fetch_data;
                    s1_valid <= 1'b1;
                end
                iqst_pkg::IQST_MV_ADV_LAT: begin
                    stage2     <= stage1;
                    s2_valid   <= s1_valid;
                    stage1     <= hold;
                    s1_valid   <= 1'b1;
                    hold_valid <= 1'b0;
                end
                iqst_pkg::IQST_MV_NONE: begin
                    if (adv_req) begin
                        s2_valid <= 1'b0;
                    end
                end
                default: begin
                    hold_valid <= hold_valid;
                end
            endcase
        end
    end

    // bus word refused while the latch is occupied
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            fetch_ready <= 1'b0;
        end else begin
            fetch_ready <= !hold_valid;
        end
    end

    // start decided at rise, takes effect for the cycle beginning at next fall
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            grant <= 1'b0;
            odd_q <= 1'b0;
            st_q  <= iqst_pkg::IQST_ST_NONE;
        end else if (e_rise) begin
            grant <= start_req && !core_busy && (avail >= 3'(`IQST_MIN_BYTES));
            odd_q <= start_odd;
            if (start_req && !core_busy && (avail >= 3'(`IQST_MIN_BYTES))) begin
                st_q <= start_odd ? iqst_pkg::IQST_ST_ODD : iqst_pkg::IQST_ST_EVEN;
            end else begin
                st_q <= iqst_pkg::IQST_ST_NONE;
            end
        end
    end

    // opcode byte from stage two as it stood before the fall update
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            exec_start  <= 1'b0;
            exec_opcode <= 8'h00;
        end else begin
            exec_start <= e_fall && grant;
            if (e_fall && grant) begin
                exec_opcode <= odd_q ? stage2[7:0] : stage2[WORD_W-1:WORD_W-8];
            end
        end
    end

    // pins: movement through the low half, start through the high half
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            queue_status_hi <= 1'b0;
            queue_status_lo <= 1'b0;
        end else if (e_fall) begin
            {queue_status_hi, queue_status_lo} <= next_mv;
        end else if (e_rise) begin
            {queue_status_hi, queue_status_lo} <= st_q_next();
        end
    end

    function automatic logic [1:0] st_q_next();
        if (start_req && !core_busy && (avail >= 3'(`IQST_MIN_BYTES))) begin
            return start_odd ? `IQST_ST_ODD : `IQST_ST_EVEN;
        end
        return `IQST_ST_NONE;
    endfunction

    chk_mux_halves: assert property (@(posedge sys_clk) disable iff (rst)
        bus_clock_out |-> ({queue_status_hi, queue_status_lo} == st_q))
        else $error("high half does not show start code");

    chk_low_half: assert property (@(posedge sys_clk) disable iff (rst)
        !bus_clock_out && $past(bus_clock_out) |-> ({queue_status_hi, queue_status_lo} == mv_q))
        else $error("low half does not show movement code");

    chk_pins_stable: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(half_end) |-> $stable({queue_status_hi, queue_status_lo}))
        else $error("status pins moved away from an E edge");

    chk_latch_code: assert property (@(posedge sys_clk) disable iff (rst)
        e_fall && next_mv == iqst_pkg::IQST_MV_LATCH |=> hold_valid && hold == $past(fetch_data))
        else $error("latch code without bus word in latch");

    chk_advance_shift: assert property (@(posedge sys_clk) disable iff (rst)
        e_fall && next_mv[1] |=> stage2 == $past(stage1))
        else $error("advance did not shift stage one");

    chk_bus_load: assert property (@(posedge sys_clk) disable iff (rst)
        e_fall && next_mv == iqst_pkg::IQST_MV_ADV_BUS |=> stage1 == $past(fetch_data))
        else $error("advance from bus loaded wrong word");

    chk_no_start: assert property (@(posedge sys_clk) disable iff (rst)
        e_fall && st_q == iqst_pkg::IQST_ST_NONE |=> !exec_start)
        else $error("start without start code");

    chk_even_byte: assert property (@(posedge sys_clk) disable iff (rst)
        e_fall && grant && !odd_q |=> exec_opcode == $past(stage2[WORD_W-1:WORD_W-8]))
        else $error("even start took wrong byte");

    chk_three_bytes: assert property (@(posedge sys_clk) disable iff (rst)
        e_rise && start_req && avail < 3'(`IQST_MIN_BYTES) |=> !grant)
        else $error("start granted with fewer than three bytes");

    chk_no_overlap: assert property (@(posedge sys_clk) disable iff (rst)
        e_rise && core_busy |=> !grant ##1 !exec_start)
        else $error("start while previous instruction busy");

    chk_start_at_fall: assert property (@(posedge sys_clk) disable iff (rst)
        exec_start |-> $past(e_fall))
        else $error("start not tied to E fall");
endmodule
`default_nettype wire

// >>> sim/iqst_trace.sv
`default_nettype none
module iqst_trace (
    input  wire logic       sys_clk,
    input  wire logic       bus_clock_out,
    input  wire logic       queue_status_hi,
    input  wire logic       queue_status_lo,
    input  wire logic       exec_start,
    input  wire logic [7:0] exec_opcode,
    output var logic [1:0]  mv,
    output var logic [1:0]  st,
    output var logic [7:0]  last_op,
    output var int          n_glitch
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] prev;
    int         glitch_cnt = 0;
    // one driver for the count port: the bench reads this copy only
    assign n_glitch = glitch_cnt;
    // sampling mid-half sees the code settled around the e edge
    always @(negedge sys_clk) begin
        if (bus_clock_out) begin
            st <= {queue_status_hi, queue_status_lo};
        end else begin
            mv <= {queue_status_hi, queue_status_lo};
        end
    end
    always @(posedge sys_clk) begin
        if (exec_start) begin
            last_op <= exec_opcode;
        end
        if (prev[2] === bus_clock_out && prev[1:0] !== {queue_status_hi, queue_status_lo}) begin
            glitch_cnt <= glitch_cnt + 1;
        end
        prev <= {bus_clock_out, queue_status_hi, queue_status_lo};
    end
endmodule
`default_nettype wire

// >>> sim/testbench.sv
`include "iqst_regs.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        fetch_valid = 1'b0;
    logic [15:0] fetch_data = 16'h0000;
    logic        adv_req = 1'b0;
    logic        start_req = 1'b0;
    logic        start_odd = 1'b0;
    logic        core_busy = 1'b0;
    logic        fetch_ready, bus_clock_out, queue_status_hi, queue_status_lo, exec_start;
    logic [7:0]  exec_opcode, last_op;
    logic [1:0]  mv, st;
    int          n_glitch, n_errors = 0, compares = 0;
    localparam logic [15:0] WA = 16'ha1b2, WB = 16'hc3d4, WC = 16'he5f6, WD = 16'h1728;

    always #12.5 sys_clk = ~sys_clk;

    iqst_tracker DUT (.sys_clk(sys_clk), .rst(rst), .fetch_valid(fetch_valid), .fetch_data(fetch_data),
        .adv_req(adv_req), .start_req(start_req), .start_odd(start_odd), .core_busy(core_busy),
        .fetch_ready(fetch_ready), .bus_clock_out(bus_clock_out), .queue_status_hi(queue_status_hi),
        .queue_status_lo(queue_status_lo), .exec_start(exec_start), .exec_opcode(exec_opcode));

    iqst_trace trace (.sys_clk(sys_clk), .bus_clock_out(bus_clock_out), .queue_status_hi(queue_status_hi),
        .queue_status_lo(queue_status_lo), .exec_start(exec_start), .exec_opcode(exec_opcode),
        .mv(mv), .st(st), .last_op(last_op), .n_glitch(n_glitch));

    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // returns on the e fall edge, before its updates land
    task automatic sync;
        logic seen1;
        seen1 = 1'b0;
        for (int k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (bus_clock_out === 1'b1 && seen1) return;
            seen1 = (bus_clock_out === 1'b1);
        end
        n_errors++;
        summarize();
    endtask

    // one e period; start code of these inputs, movement of the previous fetch
    task automatic step(input logic fv, input logic [15:0] d, input logic adv, input logic sr,
                        input logic so, input logic bz, input logic [1:0] est, input logic [1:0] emv,
                        input logic cm);
        fetch_valid <= fv;
        fetch_data <= d;
        adv_req <= adv;
        start_req <= sr;
        start_odd <= so;
        core_busy <= bz;
        repeat (4) @(posedge sys_clk);
        chk({6'h00, st}, {6'h00, est}, "start code");
        if (cm) chk({6'h00, mv}, {6'h00, emv}, "movement code");
    endtask

    task automatic t_fill;
        step(1, WA, 0, 0, 0, 0, `IQST_ST_NONE, `IQST_MV_NONE, 1'b0);
        step(1, WB, 0, 0, 0, 0, `IQST_ST_NONE, `IQST_MV_ADV_BUS, 1'b1);
        step(1, WC, 0, 1, 0, 0, `IQST_ST_EVEN, `IQST_MV_ADV_BUS, 1'b1);
        step(1, WD, 0, 1, 1, 1, `IQST_ST_NONE, `IQST_MV_LATCH, 1'b1);
        chk(last_op, WA[15:8], "even opcode");
        step(1, WD, 0, 1, 1, 0, `IQST_ST_ODD, `IQST_MV_NONE, 1'b1);
        chk({7'h00, fetch_ready}, 8'h00, "ready with latch full");
        $display("test fill done");
    endtask

    task automatic t_advance;
        step(0, 16'h0000, 1, 0, 0, 0, `IQST_ST_NONE, `IQST_MV_NONE, 1'b1);
        chk(last_op, WA[7:0], "odd opcode");
        step(0, 16'h0000, 0, 1, 0, 0, `IQST_ST_EVEN, `IQST_MV_ADV_LAT, 1'b1);
        chk({7'h00, fetch_ready}, 8'h01, "ready after latch drain");
        step(0, 16'h0000, 1, 0, 0, 0, `IQST_ST_NONE, `IQST_MV_NONE, 1'b1);
        chk(last_op, WB[15:8], "advanced opcode");
        step(0, 16'h0000, 0, 1, 1, 0, `IQST_ST_NONE, `IQST_MV_NONE, 1'b0);
        $display("test advance done");
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        chk({5'h00, queue_status_hi, queue_status_lo, exec_start}, 8'h00, "pins in reset");
        rst <= 1'b0;
        sync();
        t_fill();
        t_advance();
        chk({7'h00, n_glitch == 0}, 8'h01, "pins moved off e edges");
        summarize();
    end
endmodule
`default_nettype wire
